// File: shared/msdc_defines.svh
`ifndef MSDC_DEFINES_SVH
`define MSDC_DEFINES_SVH

// Register byte offsets
`define MSDC_OFS_CTRL      8'h00
`define MSDC_OFS_PANEL     8'h04
`define MSDC_OFS_FF0       8'h08
`define MSDC_OFS_FF1       8'h0c
`define MSDC_OFS_FF2       8'h10
`define MSDC_OFS_FF3       8'h14
`define MSDC_OFS_INCFG     8'h18
`define MSDC_OFS_SENSOR    8'h1c
`define MSDC_OFS_STATUS    8'h20
`define MSDC_OFS_SETPOINT  8'h24
`define MSDC_OFS_MEASFREQ  8'h28

// Control field positions
`define MSDC_CTRL_SRC_LO   0
`define MSDC_CTRL_BRAKE_EN 2
`define MSDC_CTRL_CODE8    3
`define MSDC_CTRL_AIN_RATE 4

// Reset values
`define MSDC_CTRL_RST      32'h0000_0000
`define MSDC_PPR_RST       4'h1

// Timing: measurement gate of 1 s at 250 MHz
`define MSDC_GATE_NS       1000000000
`define MSDC_CLK_NS        4
`define MSDC_GATE_CYC      (`MSDC_GATE_NS / `MSDC_CLK_NS)

`endif

// File: shared/msdc_pkg.sv
package msdc_pkg;

    typedef enum logic [1:0] {
        MSDC_SRC_PANEL    = 2'h0,
        MSDC_SRC_REMOTE   = 2'h1,
        MSDC_SRC_PARALLEL = 2'h2,
        MSDC_SRC_RSVD     = 2'h3
    } msdc_src_t;

    // Digital input function codes
    typedef enum logic [1:0] {
        MSDC_FN_NONE    = 2'h0,
        MSDC_FN_FIXFREQ = 2'h1,
        MSDC_FN_CCW     = 2'h2,
        MSDC_FN_RSVD    = 2'h3
    } msdc_infn_t;

    typedef struct packed {
        logic        brake;
        logic        run;
        logic        ccw;
        logic [15:0] freq;
    } msdc_drive_t;

    typedef struct packed {
        logic mains_ok;
        logic stop_cmd;
        logic start_cmd;
    } msdc_oper_t;

endpackage

// File: src/msdc_ctrl.sv
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "msdc_defines.svh"

module msdc_ctrl #(
    parameter int FREQ_W   = 16,
    parameter int GATE_CYC = `MSDC_GATE_CYC
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Avalon-MM slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Remote inputs
    input  wire logic [3:0]           digital_in,
    input  wire logic                 fixed_freq_select_lo,
    input  wire logic                 fixed_freq_select_hi,
    input  wire logic [FREQ_W-1:0]    analog_setpoint_input,
    // Operator and mains
    input  wire msdc_pkg::msdc_oper_t oper,
    // Speed sensor pulse
    input  wire logic                 sensor_pulse,
    // Power stage
    output msdc_pkg::msdc_drive_t     drive,
    output logic                      brake_full_power,
    output logic                      motor_stopped
);

    initial begin
        if (FREQ_W != 16 || GATE_CYC < 2)
            $error("msdc_ctrl: unsupported parameters");
    end
    typedef enum {ST_IDLE, ST_RUN, ST_REVERSE, ST_ESTOP, ST_LOCKED} msdc_state_t;
    logic [31:0]       ctrl;
    logic [FREQ_W-1:0] panel_frequency_setpoint;
    logic [FREQ_W-1:0] fixed_freq [4];
    logic [5:0]        in_cfg;
    logic [3:0]        sensor_pulses_per_rev_cfg;
    logic              sensor_en;
    logic [31:0]       gate_cnt;
    logic [31:0]       pulse_cnt;
    logic [FREQ_W-1:0] measured_motor_frequency;
    logic [FREQ_W-1:0] setpoint;
    logic              ccw_cur;
    logic              ack;
    msdc_state_t       state;
    msdc_state_t       next_state;

    wire [1:0] setpoint_source_selector = ctrl[`MSDC_CTRL_SRC_LO +: 2];
    wire       mains_fail_brake_enable  = ctrl[`MSDC_CTRL_BRAKE_EN];
    wire       analog_input_function_cfg = ctrl[`MSDC_CTRL_AIN_RATE];

    function automatic logic match_fn(input logic [5:0] cfg, input logic [3:0] din,
                                      input msdc_pkg::msdc_infn_t fn);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 3; i++)
            if (cfg[2*i +: 2] == fn && din[i+1])
                hit = 1'b1;
        return hit;
    endfunction

    wire prog_en = setpoint_source_selector == msdc_pkg::MSDC_SRC_REMOTE
                || setpoint_source_selector == msdc_pkg::MSDC_SRC_PARALLEL;
    wire ff_active = prog_en && match_fn(in_cfg, digital_in, msdc_pkg::MSDC_FN_FIXFREQ);
    wire [1:0] ff_idx = {fixed_freq_select_hi, fixed_freq_select_lo};
    wire ain_ok = analog_input_function_cfg;
    wire ccw_req = prog_en && match_fn(in_cfg, digital_in, msdc_pkg::MSDC_FN_CCW);

    logic [FREQ_W-1:0] next_setpoint;
    always_comb
    begin
        next_setpoint = setpoint;
        unique case (setpoint_source_selector)
            msdc_pkg::MSDC_SRC_PANEL:
                next_setpoint = panel_frequency_setpoint;
            msdc_pkg::MSDC_SRC_REMOTE:
                next_setpoint = ff_active ? fixed_freq[ff_idx]
                              : (ain_ok ? analog_setpoint_input : '0);
            msdc_pkg::MSDC_SRC_PARALLEL:
                next_setpoint = ff_active ? fixed_freq[ff_idx]
                              : (ain_ok ? analog_setpoint_input : panel_frequency_setpoint);
            default:
                next_setpoint = panel_frequency_setpoint;
        endcase
    end

    wire stopped = measured_motor_frequency == '0;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (oper.start_cmd && oper.mains_ok)
                    next_state = ST_RUN;
            ST_RUN:
                if (mains_fail_brake_enable && !oper.mains_ok)
                    next_state = ST_ESTOP;
                else if (oper.stop_cmd)
                    next_state = ST_IDLE;
                else if (ccw_req != ccw_cur)
                    next_state = ST_REVERSE;
            ST_REVERSE:
                if (stopped)
                    next_state = ST_RUN;
            ST_ESTOP:
                if (oper.stop_cmd)
                    next_state = ST_IDLE;
                else if (oper.mains_ok)
                    next_state = ST_LOCKED;
            ST_LOCKED:
                if (oper.stop_cmd)
                    next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state   <= ST_IDLE;
            ccw_cur <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE || (state == ST_REVERSE && stopped))
                ccw_cur <= ccw_req;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            setpoint <= '0;
        else
            setpoint <= next_setpoint;
    end

    wire braking = state == ST_ESTOP || state == ST_LOCKED || state == ST_REVERSE;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            drive            <= '0;
            brake_full_power <= 1'b0;
            motor_stopped    <= 1'b1;
        end
        else
        begin
            drive.run        <= state == ST_RUN;
            drive.brake      <= braking;
            drive.ccw        <= ccw_cur;
            drive.freq       <= state == ST_RUN ? setpoint : '0;
            brake_full_power <= state == ST_ESTOP || state == ST_LOCKED;
            motor_stopped    <= stopped;
        end
    end

    // gated pulse count divided by pulses per rev
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            gate_cnt                 <= '0;
            pulse_cnt                <= '0;
            measured_motor_frequency <= '0;
        end
        else if (gate_cnt == 32'(GATE_CYC - 1))
        begin
            gate_cnt                 <= '0;
            pulse_cnt                <= '0;
            measured_motor_frequency <= sensor_en
                ? FREQ_W'((pulse_cnt + 32'(sensor_pulse)) / 32'(sensor_pulses_per_rev_cfg)) : '0;
        end
        else
        begin
            gate_cnt  <= gate_cnt + 32'h1;
            pulse_cnt <= pulse_cnt + 32'(sensor_pulse);
        end
    end

    // Avalon slave: one wait cycle per access
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    wire wr = avs_write && ack;
    wire [3:0] ppr_wr = avs_writedata[3:0];
    wire ppr_ok = ppr_wr >= 4'h1 && ppr_wr <= 4'ha;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack                       <= 1'b0;
            ctrl                      <= `MSDC_CTRL_RST;
            panel_frequency_setpoint  <= '0;
            fixed_freq                <= '{default: '0};
            in_cfg                    <= '0;
            sensor_pulses_per_rev_cfg <= `MSDC_PPR_RST;
            sensor_en                 <= 1'b0;
        end
        else
        begin
            ack <= (avs_read || avs_write) && !ack;
            if (wr)
            begin
                unique case (avs_address)
                    `MSDC_OFS_CTRL:
                        ctrl <= {27'h0, avs_writedata[4],
                                 avs_writedata[3] && !sensor_en, avs_writedata[2:0]};
                    `MSDC_OFS_PANEL:  panel_frequency_setpoint <= avs_writedata[15:0];
                    `MSDC_OFS_FF0:    fixed_freq[0] <= avs_writedata[15:0];
                    `MSDC_OFS_FF1:    fixed_freq[1] <= avs_writedata[15:0];
                    `MSDC_OFS_FF2:    fixed_freq[2] <= avs_writedata[15:0];
                    `MSDC_OFS_FF3:    fixed_freq[3] <= avs_writedata[15:0];
                    `MSDC_OFS_INCFG:  in_cfg <= avs_writedata[5:0];
                    `MSDC_OFS_SENSOR:
                    begin
                        sensor_en <= avs_writedata[8] && !ctrl[`MSDC_CTRL_CODE8];
                        if (ppr_ok)
                            sensor_pulses_per_rev_cfg <= ppr_wr;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            avs_readdata <= '0;
        else if (avs_read && !ack)
        begin
            unique case (avs_address)
                `MSDC_OFS_CTRL:     avs_readdata <= ctrl;
                `MSDC_OFS_PANEL:    avs_readdata <= {16'h0, panel_frequency_setpoint};
                `MSDC_OFS_FF0:      avs_readdata <= {16'h0, fixed_freq[0]};
                `MSDC_OFS_FF1:      avs_readdata <= {16'h0, fixed_freq[1]};
                `MSDC_OFS_FF2:      avs_readdata <= {16'h0, fixed_freq[2]};
                `MSDC_OFS_FF3:      avs_readdata <= {16'h0, fixed_freq[3]};
                `MSDC_OFS_INCFG:    avs_readdata <= {26'h0, in_cfg};
                `MSDC_OFS_SENSOR:   avs_readdata <= {23'h0, sensor_en, 4'h0,
                                                     sensor_pulses_per_rev_cfg};
                `MSDC_OFS_STATUS:   avs_readdata <= {26'h0, stopped, braking,
                                                     drive.run, ccw_cur, ff_active, prog_en};
                `MSDC_OFS_SETPOINT: avs_readdata <= {16'h0, setpoint};
                `MSDC_OFS_MEASFREQ: avs_readdata <= {16'h0, measured_motor_frequency};
                default:            avs_readdata <= 32'h0;
            endcase
        end
    end

    property p_panel_sel;
        @(posedge mclk) disable iff (rst)
        setpoint_source_selector == msdc_pkg::MSDC_SRC_PANEL
        |=> setpoint == $past(panel_frequency_setpoint);
    endproperty
    a_panel_sel: assert property (p_panel_sel) else $error("panel setpoint not used");
    property p_ff_prio;
        @(posedge mclk) disable iff (rst)
        ff_active && setpoint_source_selector != msdc_pkg::MSDC_SRC_PANEL
        |=> setpoint == $past(fixed_freq[ff_idx]);
    endproperty
    a_ff_prio: assert property (p_ff_prio) else $error("fixed frequency not chosen");
    property p_no_ff_panel;
        @(posedge mclk) disable iff (rst)
        setpoint_source_selector == msdc_pkg::MSDC_SRC_PANEL |-> !ff_active && !ccw_req;
    endproperty
    a_no_ff_panel: assert property (p_no_ff_panel) else $error("inputs act in panel");
    property p_estop;
        @(posedge mclk) disable iff (rst)
        state == ST_RUN && mains_fail_brake_enable && !oper.mains_ok
        |=> state == ST_ESTOP ##1 brake_full_power;
    endproperty
    a_estop: assert property (p_estop) else $error("no emergency brake");
    property p_locked;
        @(posedge mclk) disable iff (rst)
        state == ST_LOCKED && !oper.stop_cmd |=> state == ST_LOCKED;
    endproperty
    a_locked: assert property (p_locked) else $error("restart without stop");
    property p_reverse;
        @(posedge mclk) disable iff (rst)
        state == ST_RUN && next_state == ST_REVERSE |=> ##1 drive.brake && !drive.run;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reversal without brake");
    property p_ppr;
        @(posedge mclk) disable iff (rst)
        sensor_pulses_per_rev_cfg >= 4'h1 && sensor_pulses_per_rev_cfg <= 4'ha;
    endproperty
    a_ppr: assert property (p_ppr) else $error("pulses per rev out of range");
    property p_code8;
        @(posedge mclk) disable iff (rst)
        !(sensor_en && ctrl[`MSDC_CTRL_CODE8]);
    endproperty
    a_code8: assert property (p_code8) else $error("sensor with eight-motor coding");
endmodule

// File: verif/msdc_motor_model.sv
`timescale 1ns/1ps
module msdc_motor_model #(
    parameter int PER = 4
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Power stage
    input  wire msdc_pkg::msdc_drive_t drive,
    // Speed sensor
    output logic                       sensor_pulse
);
    logic [7:0] cnt;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt          <= 8'h00;
            sensor_pulse <= 1'b0;
        end
        else
        begin
            cnt          <= (cnt == 8'(PER)) ? 8'h00 : cnt + 8'h01;
            sensor_pulse <= drive.run && !drive.brake && (cnt == 8'h00);
        end
    end
endmodule

// File: verif/motor_setpoint_direction_ctrl_tb.sv
`timescale 1ns/1ps
`include "msdc_defines.svh"
module motor_setpoint_direction_ctrl_tb;
    logic                  mclk;
    logic                  rst;
    logic [7:0]            avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic [3:0]            digital_in;
    logic                  sel_lo;
    logic                  sel_hi;
    logic [15:0]           analog;
    msdc_pkg::msdc_oper_t  oper;
    logic                  sensor_pulse;
    msdc_pkg::msdc_drive_t drive;
    logic                  brake_full_power;
    logic                  motor_stopped;
    int                    failures;
    int                    num_checks;

    msdc_ctrl #(.GATE_CYC(100)) DUT (
        .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .digital_in(digital_in), .fixed_freq_select_lo(sel_lo),
        .fixed_freq_select_hi(sel_hi), .analog_setpoint_input(analog),
        .oper(oper), .sensor_pulse(sensor_pulse), .drive(drive),
        .brake_full_power(brake_full_power), .motor_stopped(motor_stopped)
    );
    msdc_motor_model motor (
        .mclk(mclk), .rst(rst), .drive(drive), .sensor_pulse(sensor_pulse)
    );

    task automatic results();
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // Holds request until waitrequest seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        n = 0;
        // Waitrequest and read data as they stand at this edge
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (avs_waitrequest !== 1'b0)
            failures++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk($sformatf("reg %h", a), e, x);
    endtask

    task automatic until_sig(input int which, input logic v);
        int n;
        for (n = 0; n < 2000; n++)
        begin
            if (which == 0 && drive.brake === v) break;
            if (which == 1 && motor_stopped === v) break;
            if (which == 2 && drive.run === v && drive.brake === 1'b0) break;
            if (which == 3 && brake_full_power === v) break;
            @(posedge mclk);
        end
        if (n == 2000)
            failures++;
        @(posedge mclk);
    endtask

    task automatic pulse_cmd(input logic stp);
        if (stp) oper.stop_cmd <= 1'b1; else oper.start_cmd <= 1'b1;
        @(posedge mclk);
        oper.stop_cmd  <= 1'b0;
        oper.start_cmd <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic t_reset();
        rchk(`MSDC_OFS_CTRL, `MSDC_CTRL_RST);
        rchk(`MSDC_OFS_SENSOR, 32'h0000_0001);
        wr(8'h30, 32'h0000_00ff);
        rchk(8'h30, 32'h0);
        chk("stopped", 32'h1, {31'h0, motor_stopped});
    endtask

    task automatic t_setpoint();
        wr(`MSDC_OFS_PANEL, 32'h0123);
        for (int i = 0; i < 4; i++)
            wr(`MSDC_OFS_FF0 + 8'(4 * i), 32'h0a00 + i);
        wr(`MSDC_OFS_INCFG, 32'h9);
        digital_in <= 4'h2;
        wr(`MSDC_OFS_CTRL, 32'h0);
        rchk(`MSDC_OFS_SETPOINT, 32'h0123);
        wr(`MSDC_OFS_CTRL, 32'h11);
        for (int i = 0; i < 4; i++)
        begin
            {sel_hi, sel_lo} <= 2'(i);
            // Setpoint register lags its inputs by one edge
            @(posedge mclk);
            rchk(`MSDC_OFS_SETPOINT, 32'h0a00 + i);
        end
        digital_in <= 4'h0;
        @(posedge mclk);
        rchk(`MSDC_OFS_SETPOINT, 32'h0456);
        wr(`MSDC_OFS_CTRL, 32'h12);
        digital_in <= 4'h2;
        @(posedge mclk);
        rchk(`MSDC_OFS_SETPOINT, 32'h0a03);
        wr(`MSDC_OFS_CTRL, 32'h13);
        rchk(`MSDC_OFS_SETPOINT, 32'h0123);
        digital_in <= 4'h0;
    endtask

    task automatic t_sensor();
        wr(`MSDC_OFS_SENSOR, 32'h105);
        wr(`MSDC_OFS_CTRL, 32'h19);
        rchk(`MSDC_OFS_CTRL, 32'h11);
        wr(`MSDC_OFS_SENSOR, 32'h10b);
        rchk(`MSDC_OFS_SENSOR, 32'h105);
        wr(`MSDC_OFS_SENSOR, 32'h10a);
        rchk(`MSDC_OFS_SENSOR, 32'h10a);
        wr(`MSDC_OFS_SENSOR, 32'h101);
    endtask

    task automatic t_dir();
        pulse_cmd(1'b0);
        chk("run", 32'h1, {31'h0, drive.run});
        chk("ccw", 32'h0, {31'h0, drive.ccw});
        chk("freq", 32'h0456, {16'h0, drive.freq});
        until_sig(1, 1'b0);
        chk("moving", 32'h0, {31'h0, motor_stopped});
        // Model pulses every 5 cycles: 20 per 100-cycle gate at one pulse per rev
        repeat (200) @(posedge mclk);
        rchk(`MSDC_OFS_MEASFREQ, 32'h0000_0014);
        digital_in <= 4'h4;
        until_sig(0, 1'b1);
        chk("brake first", 32'h1, {31'h0, drive.brake});
        until_sig(1, 1'b1);
        chk("stop seen", 32'h1, {31'h0, motor_stopped});
        until_sig(2, 1'b1);
        chk("ccw run", 32'h1, {31'h0, drive.run & drive.ccw});
    endtask

    task automatic t_estop();
        wr(`MSDC_OFS_CTRL, 32'h15);
        oper.mains_ok <= 1'b0;
        until_sig(3, 1'b1);
        chk("full brake", 32'h1, {31'h0, brake_full_power});
        chk("brake", 32'h1, {31'h0, drive.brake});
        oper.mains_ok <= 1'b1;
        repeat (4) @(posedge mclk);
        pulse_cmd(1'b0);
        chk("no restart", 32'h0, {31'h0, drive.run & !drive.brake});
        pulse_cmd(1'b1);
        pulse_cmd(1'b0);
        until_sig(2, 1'b1);
        chk("restart", 32'h1, {31'h0, drive.run});
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #40000;
        failures++;
        results();
    end

    initial
    begin
        failures      = 0;
        num_checks    = 0;
        rst           = 1'b1;
        avs_address   = 8'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        digital_in    = 4'h0;
        sel_lo        = 1'b0;
        sel_hi        = 1'b0;
        analog        = 16'h0456;
        oper          = '{mains_ok: 1'b1, stop_cmd: 1'b0, start_cmd: 1'b0};
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_setpoint();
        t_sensor();
        t_dir();
        t_estop();
        results();
    end
endmodule
